// *** omsel_top.v ***
// operating mode selector: pushbutton timing, key checks, mode outputs, backlight
// assumes button and key status inputs are asynchronous; lock, ack and readback are too
//
// Behaviour
// - restart into mode one or stored mode
// - power-on enters mode one unless CFG_RESTORE, regardless of key
// - error in modes 1-4 keeps mode and light
// - service error keeps output, lights all same
// - key valid throughout whole press, authorised at release
// - multiple buttons pressed rejects the change
// - chosen button of modes 1-4 lit steadily after release
// - free change among modes one to four
// - button one long press enters flashing service
// - service reachable from any mode
// - modes 1-4 need press 50 ms to 5 s
// - service needs press 5 s to 10 s
// - output rises after release plus switchover delay
// - at most one mode output high
// - key removal completes selection
// - configuration switch change while running is device error
// - stuck mode output is device error
// - device error held until power cycle
`timescale 1ns/1ps
`include "omsel_regs.vh"

module omsel_top #(
    parameter MIN_CYC = `OMSEL_CYC(`OMSEL_T_MIN_MS),
    parameter SVC_CYC = `OMSEL_CYC(`OMSEL_T_SVC_MS),
    parameter MAX_CYC = `OMSEL_CYC(`OMSEL_T_MAX_MS),
    parameter SWITCH_CYC = `OMSEL_CYC(`OMSEL_T_SWITCH_MS),
    parameter LOCK_CYC = `OMSEL_CYC(`OMSEL_T_LOCK_MS),
    parameter FLASH_CYC = `OMSEL_CYC(`OMSEL_T_FLASH_MS),
    parameter DEB_CYC = `OMSEL_CYC(`OMSEL_T_DEB_MS),
    parameter CHECK_CYC = `OMSEL_CYC(`OMSEL_T_SWITCH_MS)
) (
    // clock and reset
    input wire CLK_SYS,
    input wire NRST,
    // pushbuttons, one bit per button, high while pressed
    input wire [3:0] BUTTON,
    // transponder key status
    input wire KEY_VALID,
    input wire [4:0] KEY_AUTH,
    // configuration: 1 restarts into the stored mode
    input wire CFG_RESTORE,
    input wire [2:0] CFG_STORED_MODE,
    input wire [7:0] CFG_SWITCH,
    // controller handshake
    input wire MODE_LOCK,
    input wire OUT_ACK,
    // readback of the mode output pins
    input wire [4:0] MODE_SENSE,
    // internal fault report
    input wire INT_FAULT,
    // mode outputs
    output reg MODE_OUTPUT_ONE,
    output reg MODE_OUTPUT_TWO,
    output reg MODE_OUTPUT_THREE,
    output reg MODE_OUTPUT_FOUR,
    output reg SERVICE_MODE_OUTPUT,
    // pushbutton backlight and status
    output reg [3:0] BUTTON_LIGHT,
    output reg DEVICE_ERROR,
    output reg KEY_REMOVED
);

    // =====================================================
    // state codes of the selection sequencer
    localparam ST_INIT = 3'h0;
    localparam ST_IDLE = 3'h1;
    localparam ST_PRESS = 3'h2;
    localparam ST_WAIT = 3'h3;
    localparam ST_SWITCH = 3'h4;

    // =====================================================
    // input synchronisers: three stages, change once stages two and three agree
    wire [12:0] raw_in = {KEY_VALID, KEY_AUTH, MODE_LOCK, OUT_ACK, BUTTON, INT_FAULT};
    reg [12:0] sync1, sync2, sync3; // stage chain
    reg [12:0] clean; // agreed level
    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            sync1 <= 13'h0000;
            sync2 <= 13'h0000;
            sync3 <= 13'h0000;
            clean <= 13'h0000;
        end else begin
            sync1 <= raw_in;
            sync2 <= sync1;
            sync3 <= sync2;
            clean <= (sync2 & sync3) | (clean & (sync2 | sync3));
        end
    end
    wire key_valid = clean[12];
    wire [4:0] key_auth = clean[11:7];
    wire lock_raw = clean[6];
    wire ack = clean[5];
    wire [3:0] btn_raw = clean[4:1];
    wire int_fault = clean[0];

    // mode readback also passes three stages
    reg [4:0] sense1, sense2, sense3;
    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            sense1 <= 5'h00;
            sense2 <= 5'h00;
            sense3 <= 5'h00;
        end else begin
            sense1 <= MODE_SENSE;
            sense2 <= sense1;
            sense3 <= sense2;
        end
    end

    // configuration switch passes three stages too, so a one-cycle glitch cannot latch an error
    reg [7:0] cfg1, cfg2, cfg3;
    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            cfg1 <= 8'h00;
            cfg2 <= 8'h00;
            cfg3 <= 8'h00;
        end else begin
            cfg1 <= CFG_SWITCH;
            cfg2 <= cfg1;
            cfg3 <= cfg2;
        end
    end

    // =====================================================
    // per-button debounce: a level must hold DEB_CYC cycles
    wire [3:0] btn; // debounced buttons
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_deb
            reg [23:0] deb_cnt; // cycles the raw level has differed
            reg btn_q; // one flip-flop per button keeps a single driver per bit
            assign btn[gi] = btn_q;
            always @(posedge CLK_SYS or negedge NRST) begin
                if (!NRST) begin
                    deb_cnt <= 24'h000000;
                    btn_q <= 1'b0;
                end else if (btn_raw[gi] == btn_q) begin
                    deb_cnt <= 24'h000000;
                end else if (deb_cnt >= DEB_CYC - 1) begin
                    deb_cnt <= 24'h000000;
                    btn_q <= btn_raw[gi];
                end else begin
                    deb_cnt <= deb_cnt + 24'h000001;
                end
            end
        end
    endgenerate

    // =====================================================
    // lock filter: the controller level is adopted after LOCK_CYC stable cycles
    reg lock_en; // 1 allows mode changes
    reg [23:0] lock_cnt;
    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            lock_en <= 1'b0;
            lock_cnt <= 24'h000000;
        end else if (lock_raw == lock_en) begin
            lock_cnt <= 24'h000000;
        end else if (lock_cnt >= LOCK_CYC - 1) begin
            lock_cnt <= 24'h000000;
            lock_en <= lock_raw;
        end else begin
            lock_cnt <= lock_cnt + 24'h000001;
        end
    end

    // =====================================================
    // flash timer for service backlighting
    reg [23:0] flash_cnt;
    reg flash;
    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            flash_cnt <= 24'h000000;
            flash <= 1'b0;
        end else if (flash_cnt >= FLASH_CYC - 1) begin
            flash_cnt <= 24'h000000;
            flash <= ~flash;
        end else begin
            flash_cnt <= flash_cnt + 24'h000001;
        end
    end

    // =====================================================
    // selection sequencer
    reg [2:0] state;
    reg [2:0] mode; // active mode
    reg [2:0] target; // mode chosen by the last press
    reg [3:0] press_btn; // button held in this press
    reg press_ok; // key stayed valid, single button
    reg [27:0] press_cnt; // press duration
    reg [23:0] sw_cnt; // switchover delay counter
    reg [7:0] cfg_seen; // switch setting captured after reset
    reg fault; // device error latch
    reg key_prev;

    // one-hot count check on the button vector
    wire multi = (btn[0] & btn[1]) | (btn[0] & btn[2]) | (btn[0] & btn[3]) |
                 (btn[1] & btn[2]) | (btn[1] & btn[3]) | (btn[2] & btn[3]);

    // authorisation for the pressed button under the chosen window
    reg [2:0] pick;
    reg pick_ok;
    always @* begin
        pick = mode;
        pick_ok = 1'b0;
        if (press_cnt > MIN_CYC && press_cnt < SVC_CYC) begin
            case (press_btn)
                4'h1: begin pick = `OMSEL_MODE_ONE; pick_ok = key_auth[0]; end
                4'h2: begin pick = `OMSEL_MODE_TWO; pick_ok = key_auth[1]; end
                4'h4: begin pick = `OMSEL_MODE_THREE; pick_ok = key_auth[2]; end
                4'h8: begin pick = `OMSEL_MODE_FOUR; pick_ok = key_auth[3]; end
                default: pick_ok = 1'b0;
            endcase
        end else if (press_cnt > SVC_CYC && press_cnt < MAX_CYC && press_btn == 4'h1) begin
            pick = `OMSEL_MODE_SVC;
            pick_ok = key_auth[4];
        end
    end

    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            state <= ST_INIT;
            mode <= `OMSEL_MODE_RESET;
            target <= `OMSEL_MODE_RESET;
            press_btn <= 4'h0;
            press_ok <= 1'b0;
            press_cnt <= 28'h0000000;
            sw_cnt <= 24'h000000;
            cfg_seen <= 8'h00;
            fault <= 1'b0;
            key_prev <= 1'b0;
            KEY_REMOVED <= 1'b0;
        end else begin
            key_prev <= key_valid;
            KEY_REMOVED <= key_prev & ~key_valid; // selection already done
            // device faults latch until power cycle
            // the switch is judged only once its settled value has been captured
            if (state != ST_INIT && state != ST_SWITCH && cfg2 == cfg3 && cfg3 != cfg_seen)
                fault <= 1'b1;
            if (int_fault)
                fault <= 1'b1;
            case (state)
                ST_INIT: begin
                    // restart mode chosen by the configuration
                    if (CFG_RESTORE && CFG_STORED_MODE <= `OMSEL_MODE_SVC)
                        mode <= CFG_STORED_MODE;
                    else
                        mode <= `OMSEL_MODE_ONE;
                    sw_cnt <= 24'h000000;
                    state <= ST_SWITCH;
                end
                ST_IDLE: begin
                    // a fault freezes the mode; no new press is taken
                    if (!fault && !DEVICE_ERROR && |btn) begin
                        press_btn <= btn;
                        press_ok <= key_valid & ~multi;
                        press_cnt <= 28'h0000001;
                        state <= ST_PRESS;
                    end
                end
                ST_PRESS: begin
                    if (!key_valid || multi || (|(btn & ~press_btn)))
                        press_ok <= 1'b0;
                    if (press_cnt != 28'hFFFFFFF)
                        press_cnt <= press_cnt + 28'h0000001;
                    if (btn == 4'h0) begin
                        // evaluate at release
                        if (press_ok && pick_ok && lock_en && !fault && !DEVICE_ERROR) begin
                            target <= pick;
                            sw_cnt <= 24'h000000;
                            state <= ST_WAIT;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_WAIT: begin
                    // all mode outputs are dark during the delay
                    if (sw_cnt >= SWITCH_CYC - 1 && ack) begin
                        // an error during the delay brings back the old mode after the full gap
                        if (!fault && !DEVICE_ERROR)
                            mode <= target;
                        state <= ST_IDLE;
                    end else if (sw_cnt < SWITCH_CYC - 1) begin
                        sw_cnt <= sw_cnt + 24'h000001;
                    end
                end
                ST_SWITCH: begin
                    // power-on delay before the first output rises
                    cfg_seen <= cfg3; // settled switch; needs SWITCH_CYC of three or more
                    if (sw_cnt >= SWITCH_CYC - 1)
                        state <= ST_IDLE;
                    else
                        sw_cnt <= sw_cnt + 24'h000001;
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // =====================================================
    // stuck-output check: readback must match drive; CHECK_CYC must exceed the whole readback lag
    reg [4:0] drive;
    reg [23:0] mis_cnt;
    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            mis_cnt <= 24'h000000;
            DEVICE_ERROR <= 1'b0;
        end else begin
            if (sense3 != drive && sense2 == sense3) begin
                if (mis_cnt >= CHECK_CYC - 1)
                    DEVICE_ERROR <= 1'b1;
                else
                    mis_cnt <= mis_cnt + 24'h000001;
            end else begin
                mis_cnt <= 24'h000000;
            end
            if (fault)
                DEVICE_ERROR <= 1'b1;
        end
    end

    // =====================================================
    // output stage: one-hot from the active mode, dark while switching
    always @* begin
        drive = 5'h00;
        if (state == ST_IDLE || state == ST_PRESS)
            drive[mode] = 1'b1;
    end

    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            MODE_OUTPUT_ONE <= 1'b0;
            MODE_OUTPUT_TWO <= 1'b0;
            MODE_OUTPUT_THREE <= 1'b0;
            MODE_OUTPUT_FOUR <= 1'b0;
            SERVICE_MODE_OUTPUT <= 1'b0;
            BUTTON_LIGHT <= 4'h0;
        end else begin
            // outputs keep the mode through an error
            MODE_OUTPUT_ONE <= drive[0];
            MODE_OUTPUT_TWO <= drive[1];
            MODE_OUTPUT_THREE <= drive[2];
            MODE_OUTPUT_FOUR <= drive[3];
            SERVICE_MODE_OUTPUT <= drive[4];
            if (mode == `OMSEL_MODE_SVC)
                BUTTON_LIGHT <= (fault || DEVICE_ERROR) ? 4'hF : {4{flash}};
            else if (drive != 5'h00)
                BUTTON_LIGHT <= 4'h1 << mode[1:0];
            else
                BUTTON_LIGHT <= 4'h0;
        end
    end

endmodule // omsel_top

// *** omsel_regs.vh ***
// timing constants, mode codes and reset values for the operating mode selector
// assumes a 10 MHz system clock; counts are derived from times in ms
`ifndef OMSEL_REGS_VH
`define OMSEL_REGS_VH
// =====================================================
// clock
`define OMSEL_CLK_KHZ 10000
// =====================================================
// press window times in ms
`define OMSEL_T_MIN_MS 50
`define OMSEL_T_SVC_MS 5000
`define OMSEL_T_MAX_MS 10000
// switchover delay in ms
`define OMSEL_T_SWITCH_MS 100
// lock input settle time in ms
`define OMSEL_T_LOCK_MS 20
// flash half period in ms
`define OMSEL_T_FLASH_MS 250
// debounce time in ms
`define OMSEL_T_DEB_MS 10
// =====================================================
// cycle counts derived from the times
`define OMSEL_CYC(ms) ((ms) * `OMSEL_CLK_KHZ)
// =====================================================
// mode codes
`define OMSEL_MODE_ONE 3'h0
`define OMSEL_MODE_TWO 3'h1
`define OMSEL_MODE_THREE 3'h2
`define OMSEL_MODE_FOUR 3'h3
`define OMSEL_MODE_SVC 3'h4
// reset value of the mode register
`define OMSEL_MODE_RESET 3'h0
`endif

// *** omsel_top_chk.sv ***
// checker for the mode selector: watches the top module's outputs only
// assumes one clock, CLK_SYS, with NRST as its asynchronous reset
`timescale 1ns/1ps
module omsel_top_chk #(
    parameter SWITCH_CYC = 4
) (
    // clock and reset
    input wire CLK_SYS,
    input wire NRST,
    // mode outputs
    input wire MODE_OUTPUT_ONE,
    input wire MODE_OUTPUT_TWO,
    input wire MODE_OUTPUT_THREE,
    input wire MODE_OUTPUT_FOUR,
    input wire SERVICE_MODE_OUTPUT,
    // backlight and status
    input wire [3:0] BUTTON_LIGHT,
    input wire DEVICE_ERROR,
    input wire KEY_REMOVED
);
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!NRST);
    // ========
    // helper logic
    wire [4:0] outs = {SERVICE_MODE_OUTPUT, MODE_OUTPUT_FOUR, MODE_OUTPUT_THREE, MODE_OUTPUT_TWO, MODE_OUTPUT_ONE};
    // run of cycles with all outputs low; saturates so a long idle never wraps
    reg [7:0] zero_cnt;
    always @(posedge CLK_SYS or negedge NRST) begin
        if (!NRST) begin
            zero_cnt <= 8'h00;
        end else if (outs != 5'h00) begin
            zero_cnt <= 8'h00;
        end else if (zero_cnt != 8'hFF) begin
            zero_cnt <= zero_cnt + 8'h01;
        end
    end
    // ========
    // assertions
    one_hot_a: assert property ($onehot0(outs)) else $error("two mode outputs high");
    err_latch_a: assert property (DEVICE_ERROR |=> DEVICE_ERROR) else $error("device error dropped");
    err_keep_a: assert property (DEVICE_ERROR && outs != 5'h00 |=> outs == $past(outs))
        else $error("mode changed while in error");
    svc_err_light_a: assert property ((SERVICE_MODE_OUTPUT && DEVICE_ERROR)[*3] |-> BUTTON_LIGHT == 4'hF)
        else $error("service error lights not all on");
    mode_light_a: assert property ((outs[3:0] != 4'h0)[*2] |-> BUTTON_LIGHT == outs[3:0])
        else $error("backlight differs from mode");
    svc_flash_a: assert property ((SERVICE_MODE_OUTPUT && !DEVICE_ERROR)[*2]
        |-> BUTTON_LIGHT == 4'h0 || BUTTON_LIGHT == 4'hF) else $error("service lights not in step");
    key_pulse_a: assert property (KEY_REMOVED |=> !KEY_REMOVED) else $error("key removal pulse too long");
    // a rising output must follow a full switchover gap with every output low
    switch_gap_a: assert property (outs != 5'h00 && $past(outs) == 5'h00 |-> zero_cnt >= SWITCH_CYC)
        else $error("output rose before switchover delay");
    // main scenarios
    cover property ($rose(SERVICE_MODE_OUTPUT));
    cover property ($rose(DEVICE_ERROR));
    cover property ($rose(MODE_OUTPUT_FOUR));
    cover property (zero_cnt == 8'h10);
endmodule // omsel_top_chk

// *** omsel_ctrl_model.sv ***
// safety controller model: drives lock and acknowledge, reads mode outputs back
// assumes the design's outputs on mode_out; stuck is commanded by the bench
`timescale 1ns/1ps
module omsel_ctrl_model #(
    parameter LAG = 2
) (
    // clock and reset
    input wire clk_sys,
    input wire nrst,
    // mode outputs and fault command
    input wire [4:0] mode_out,
    input wire stuck,
    // bench commands: hold the lock or the acknowledge at zero
    input wire lock_hold,
    input wire ack_hold,
    // handshake and readback
    output reg mode_lock,
    output reg out_ack,
    output wire [4:0] mode_sense
);
    // readback pipe; LAG must stay under the design's stuck-check count
    reg [4:0] pipe [0:3];
    integer i;
    // external voltage holds the service pin high while stuck is set
    assign mode_sense = pipe[LAG - 1] | {stuck, 4'h0};
    // ========
    // handshake: levels follow the bench's hold commands, changed at a clock edge
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mode_lock <= 1'b0;
            out_ack <= 1'b0;
            for (i = 0; i < 4; i = i + 1) pipe[i] <= 5'h00;
        end else begin
            mode_lock <= ~lock_hold;
            out_ack <= ~ack_hold;
            pipe[0] <= mode_out;
            for (i = 1; i < 4; i = i + 1) pipe[i] <= pipe[i - 1];
        end
    end
endmodule // omsel_ctrl_model

// *** omsel_tb.sv ***
// self-checking bench for the mode selector with a controller model
// assumes shortened counts: min 5, service 50, max 100, switchover 4, stuck check 12 cycles
`timescale 1ns/1ps
module tb;
    // ========
    // stimulus and observation
    reg clk_sys = 1'b0;
    reg nrst, key_valid, cfg_restore, int_fault, stuck, lock_hold, ack_hold;
    reg [3:0] button;
    reg [4:0] key_auth;
    reg [2:0] cfg_stored_mode;
    reg [7:0] cfg_switch;
    wire mode_lock, out_ack, dev_err, key_removed;
    wire [4:0] outs, sense;
    wire [3:0] light;
    // error, lights, outputs in one word for compact compares
    wire [9:0] obs = {dev_err, light, outs};
    integer n_fail = 0;
    integer check_count = 0;
    integer i, seen;
    // shortened counts; the stuck check must outlast output, model and sync lag
    localparam T_MIN = 5;
    localparam T_SVC = 50;
    localparam T_MAX = 100;
    localparam T_SWITCH = 4;
    localparam T_LOCK = 3;
    localparam T_FLASH = 4;
    localparam T_DEB = 2;
    localparam T_CHECK = 12;
    always #50 clk_sys = ~clk_sys;
    omsel_top #(.MIN_CYC(T_MIN), .SVC_CYC(T_SVC), .MAX_CYC(T_MAX), .SWITCH_CYC(T_SWITCH), .LOCK_CYC(T_LOCK),
        .FLASH_CYC(T_FLASH), .DEB_CYC(T_DEB), .CHECK_CYC(T_CHECK)) omsel_top_inst (.CLK_SYS(clk_sys), .NRST(nrst),
        .BUTTON(button),
        .KEY_VALID(key_valid), .KEY_AUTH(key_auth), .CFG_RESTORE(cfg_restore), .CFG_STORED_MODE(cfg_stored_mode),
        .CFG_SWITCH(cfg_switch), .MODE_LOCK(mode_lock), .OUT_ACK(out_ack), .MODE_SENSE(sense),
        .INT_FAULT(int_fault), .MODE_OUTPUT_ONE(outs[0]), .MODE_OUTPUT_TWO(outs[1]), .MODE_OUTPUT_THREE(outs[2]),
        .MODE_OUTPUT_FOUR(outs[3]), .SERVICE_MODE_OUTPUT(outs[4]), .BUTTON_LIGHT(light),
        .DEVICE_ERROR(dev_err), .KEY_REMOVED(key_removed));
    omsel_ctrl_model omsel_ctrl_model_inst (.clk_sys(clk_sys), .nrst(nrst), .mode_out(outs), .stuck(stuck),
        .lock_hold(lock_hold), .ack_hold(ack_hold), .mode_lock(mode_lock), .out_ack(out_ack), .mode_sense(sense));
    // ========
    // tasks; inputs change only at the falling edge
    task cyc(input integer n);
        repeat (n) @(negedge clk_sys);
    endtask
    task give_verdict;
        begin
            if (n_fail == 0 && check_count > 0) $display("Simulation passed");
            else $display("Simulation failed");
            $finish;
        end
    endtask
    // poll for the masked value under a bound; running out is a mismatch
    task expect_obs(input [9:0] exp, input [9:0] mask);
        integer k;
        begin
            k = 0;
            while (k < 60 && (obs & mask) !== (exp & mask)) begin
                cyc(1);
                k = k + 1;
            end
            check_count = check_count + 1;
            if ((obs & mask) !== (exp & mask)) begin
                $display("wrong value at %0t: got %h want %h", $time, obs, exp);
                n_fail = n_fail + 1;
                give_verdict;
            end
        end
    endtask
    // hold a button pattern, release, let a refused press settle, then compare
    task sel(input [3:0] b, input integer hold, input integer settle, input [9:0] exp, input [9:0] mask);
        begin
            button = b;
            cyc(hold);
            button = 4'h0;
            cyc(settle);
            expect_obs(exp, mask);
        end
    endtask
    task do_reset(input r, input [2:0] m);
        begin
            nrst = 1'b0;
            cfg_restore = r;
            cfg_stored_mode = m;
            cyc(12);
            nrst = 1'b1;
        end
    endtask
    // ========
    // hang guard
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_fail = n_fail + 1;
        give_verdict;
    end
    // ========
    // main sequence
    initial begin
        button = 4'h0;
        key_valid = 1'b1;
        key_auth = 5'h1F;
        cfg_switch = 8'h5A;
        int_fault = 1'b0;
        stuck = 1'b0;
        lock_hold = 1'b0;
        ack_hold = 1'b0;
        do_reset(1'b0, 3'h0);
        expect_obs(10'h021, 10'h3FF);
        sel(4'h4, 20, 0, 10'h084, 10'h3FF);
        sel(4'h2, 3, 30, 10'h084, 10'h3FF);
        sel(4'h8, 60, 30, 10'h084, 10'h3FF);
        // a second button joining a running press must void it
        button = 4'h2;
        cyc(8);
        sel(4'h3, 12, 30, 10'h084, 10'h3FF);
        sel(4'h3, 20, 30, 10'h084, 10'h3FF);
        key_auth = 5'h1D;
        sel(4'h2, 20, 30, 10'h084, 10'h3FF);
        key_auth = 5'h1F;
        // key lost in mid-press must void the press
        button = 4'h2;
        cyc(8);
        key_valid = 1'b0;
        seen = 0;
        for (i = 0; i < 8; i = i + 1) begin
            cyc(1);
            if (key_removed === 1'b1) seen = seen + 1;
        end
        check_count = check_count + 1;
        if (seen != 1) begin
            $display("wrong value at %0t: key removal pulse missing", $time);
            n_fail = n_fail + 1;
        end
        key_valid = 1'b1;
        sel(4'h2, 8, 30, 10'h084, 10'h3FF);
        sel(4'h8, 20, 0, 10'h108, 10'h3FF);
        // controller lock at zero refuses a valid press
        lock_hold = 1'b1;
        cyc(12);
        sel(4'h2, 20, 30, 10'h108, 10'h3FF);
        lock_hold = 1'b0;
        cyc(12);
        // acknowledge at zero keeps every output dark after the delay
        ack_hold = 1'b1;
        sel(4'h2, 20, 40, 10'h000, 10'h3FF);
        ack_hold = 1'b0;
        expect_obs(10'h042, 10'h3FF);
        sel(4'h1, 75, 0, 10'h010, 10'h21F);
        seen = 0;
        for (i = 0; i < 12; i = i + 1) begin
            cyc(1);
            if (light === 4'hF) seen = seen | 1;
            if (light === 4'h0) seen = seen | 2;
        end
        check_count = check_count + 1;
        if (seen != 3) begin
            $display("wrong value at %0t: service lights not flashing", $time);
            n_fail = n_fail + 1;
        end
        int_fault = 1'b1;
        expect_obs(10'h3F0, 10'h3FF);
        int_fault = 1'b0;
        sel(4'h2, 20, 30, 10'h3F0, 10'h3FF);
        do_reset(1'b1, 3'h1);
        expect_obs(10'h042, 10'h3FF);
        cfg_switch = 8'hA5;
        expect_obs(10'h242, 10'h3FF);
        // a stored code beyond service falls back to mode one
        do_reset(1'b1, 3'h7);
        expect_obs(10'h021, 10'h3FF);
        stuck = 1'b1;
        expect_obs(10'h221, 10'h3FF);
        give_verdict;
    end
endmodule // tb
bind omsel_top omsel_top_chk #(.SWITCH_CYC(SWITCH_CYC)) omsel_top_chk_inst (.CLK_SYS(CLK_SYS), .NRST(NRST),
    .MODE_OUTPUT_ONE(MODE_OUTPUT_ONE), .MODE_OUTPUT_TWO(MODE_OUTPUT_TWO), .MODE_OUTPUT_THREE(MODE_OUTPUT_THREE),
    .MODE_OUTPUT_FOUR(MODE_OUTPUT_FOUR), .SERVICE_MODE_OUTPUT(SERVICE_MODE_OUTPUT), .BUTTON_LIGHT(BUTTON_LIGHT),
    .DEVICE_ERROR(DEVICE_ERROR), .KEY_REMOVED(KEY_REMOVED));
